/* File: rtl/pcl_regs.vh */
// Constants for the parallel configuration loader
// Assumes inclusion by bare name from rtl/
`ifndef PCL_REGS_VH
`define PCL_REGS_VH
`define PCL_DATA_W        32
`define PCL_FIFO_DEPTH    8
`define PCL_FIFO_AW       3
`define PCL_POR_NS        1000
`define PCL_CLK_NS        25
`define PCL_POR_CYC       ((`PCL_POR_NS + `PCL_CLK_NS - 1) / `PCL_CLK_NS)
`define PCL_CNT_W         16
`define PCL_RATIO_PLAIN   4'h1
`define PCL_RATIO_COMP    4'h4
`define PCL_RATIO_SEC     4'h4
`define PCL_RATIO_BOTH    4'h8
`define PCL_TAIL_EDGES    2'h2
`define PCL_OPT_INIT_BIT  0
`define PCL_OPT_WORD      16'h0000
`define PCL_IMG_WORDS     16'h0010
`define PCL_ONE16         16'h0001
`define PCL_ONE4          4'h1
`endif

/* File: rtl/pcl_fifo.v */
// Word FIFO between configuration capture and the image sink
// Assumes one clock domain with the loader core
`timescale 1ns/1ps
module pcl_fifo #(
  parameter WIDTH = 32,
  parameter DEPTH = 8,
  parameter AW    = 3
) (
  input  wire             i_sys_clk,
  input  wire             i_rst,
  input  wire             i_ce,
  input  wire             i_flush,
  input  wire             i_in_valid,
  output wire             o_in_ready,
  input  wire [WIDTH-1:0] i_in_data,
  output wire             o_out_valid,
  input  wire             i_out_ready,
  output wire [WIDTH-1:0] o_out_data
);
  reg [WIDTH-1:0] mem_r [0:DEPTH-1];
  reg [AW-1:0]    wr_r;
  reg [AW-1:0]    rd_r;
  reg [AW:0]      cnt_r;
  wire            push;
  wire            pop;
  // Depth is a power of two, so the top count bit marks full
  assign o_in_ready  = ~cnt_r[AW];
  assign o_out_valid = (cnt_r != {(AW+1){1'b0}});
  assign o_out_data  = mem_r[rd_r];
  assign push        = i_in_valid & o_in_ready;
  assign pop         = o_out_valid & i_out_ready;
  always @(posedge i_sys_clk) begin
    if (i_rst || (i_ce && i_flush)) begin
      wr_r  <= {AW{1'b0}};
      rd_r  <= {AW{1'b0}};
      cnt_r <= {(AW+1){1'b0}};
    end else if (i_ce) begin
      if (push) begin
        mem_r[wr_r] <= i_in_data;
        wr_r        <= wr_r + {{(AW-1){1'b0}}, 1'b1};
      end
      if (pop)
        rd_r <= rd_r + {{(AW-1){1'b0}}, 1'b1};
      if (push && !pop)
        cnt_r <= cnt_r + {{AW{1'b0}}, 1'b1};
      else if (pop && !push)
        cnt_r <= cnt_r - {{AW{1'b0}}, 1'b1};
    end
  end
endmodule

/* File: rtl/pcl_loader.v */
// Device-side fast parallel configuration loader
// Behaviour
// - User mode holds pins high; request restarts
// - Status held low for power-on delay
// - Load-complete low until image received
// - Configuration clock ignored after completion
// - Each word spans ratio-selected clock count
// - Load-complete rises after error-free image
// - Two falling edges start init, user mode
// - Init pin low once option word loaded with init bit set
// Assumes the host drives pins asynchronously; everything is resynchronised here.
`timescale 1ns/1ps
`include "pcl_regs.vh"
module pcl_loader (
  input  wire                   i_sys_clk,
  input  wire                   i_rst,
  input  wire                   i_ce,
  input  wire                   i_reconfig_request_n,
  input  wire                   i_cfg_clock,
  input  wire [`PCL_DATA_W-1:0] i_cfg_data,
  input  wire                   i_decompress_en,
  input  wire                   i_security_en,
  input  wire                   i_word_ready,
  output reg                    o_cfg_ready_low,
  output reg                    o_load_complete,
  output reg                    o_init_done,
  output reg                    o_init_done_oe,
  output reg                    o_user_io_en,
  output reg                    o_word_valid,
  output reg  [`PCL_DATA_W-1:0] o_word_data,
  output reg                    o_error
);
  // Loader states
  localparam ST_POR  = 3'h0;
  localparam ST_LOAD = 3'h1;
  localparam ST_TAIL = 3'h2;
  localparam ST_USER = 3'h3;
  localparam ST_ERR  = 3'h4;
  reg [2:0]             state_r;
  reg [`PCL_CNT_W-1:0]  por_r;
  reg [`PCL_CNT_W-1:0]  words_r;
  reg [3:0]             edge_r;
  reg [1:0]             tail_r;
  reg                   req_s0_r;
  reg                   req_s1_r;
  reg                   clk_s0_r;
  reg                   clk_s1_r;
  reg                   clk_d_r;
  reg [`PCL_DATA_W-1:0] dat_s0_r;
  reg [`PCL_DATA_W-1:0] dat_s1_r;
  reg                   dec_s0_r;
  reg                   dec_s1_r;
  reg                   sec_s0_r;
  reg                   sec_s1_r;
  reg                   fifo_flush_r;
  wire                  rise;
  wire                  fall;
  wire [3:0]            ratio;
  wire                  cap;
  wire                  f_in_ready;
  wire                  f_out_valid;
  wire [`PCL_DATA_W-1:0] f_out_data;
  assign rise  = clk_s1_r & ~clk_d_r;
  assign fall  = ~clk_s1_r & clk_d_r;
  assign ratio = (dec_s1_r && sec_s1_r) ? `PCL_RATIO_BOTH :
                 dec_s1_r ? `PCL_RATIO_COMP :
                 sec_s1_r ? `PCL_RATIO_SEC : `PCL_RATIO_PLAIN;
  // Word latched on the first rising edge of each ratio group; nothing after the last word
  assign cap   = (state_r == ST_LOAD) && rise && (edge_r == 4'h0) && (words_r != `PCL_IMG_WORDS);

  // Two-flop synchronisers for every host pin and strap
  always @(posedge i_sys_clk) begin
    if (i_rst) begin
      req_s0_r <= 1'b0;
      req_s1_r <= 1'b0;
      clk_s0_r <= 1'b0;
      clk_s1_r <= 1'b0;
      clk_d_r  <= 1'b0;
      dat_s0_r <= {`PCL_DATA_W{1'b0}};
      dat_s1_r <= {`PCL_DATA_W{1'b0}};
      dec_s0_r <= 1'b0;
      dec_s1_r <= 1'b0;
      sec_s0_r <= 1'b0;
      sec_s1_r <= 1'b0;
    end else if (i_ce) begin
      req_s0_r <= i_reconfig_request_n;
      req_s1_r <= req_s0_r;
      clk_s0_r <= i_cfg_clock;
      clk_s1_r <= clk_s0_r;
      clk_d_r  <= clk_s1_r;
      dat_s0_r <= i_cfg_data;
      dat_s1_r <= dat_s0_r;
      dec_s0_r <= i_decompress_en;
      dec_s1_r <= dec_s0_r;
      sec_s0_r <= i_security_en;
      sec_s1_r <= sec_s0_r;
    end
  end

  pcl_fifo #(
    .WIDTH (`PCL_DATA_W),
    .DEPTH (`PCL_FIFO_DEPTH),
    .AW    (`PCL_FIFO_AW)
  ) u_fifo (
    .i_sys_clk   (i_sys_clk),
    .i_rst       (i_rst),
    .i_ce        (i_ce),
    .i_flush     (fifo_flush_r),
    .i_in_valid  (cap),
    .o_in_ready  (f_in_ready),
    .i_in_data   (dat_s1_r),
    .o_out_valid (f_out_valid),
    .i_out_ready (i_word_ready),
    .o_out_data  (f_out_data)
  );

  always @(posedge i_sys_clk) begin
    if (i_rst) begin
      state_r         <= ST_POR;
      por_r           <= {`PCL_CNT_W{1'b0}};
      words_r         <= {`PCL_CNT_W{1'b0}};
      edge_r          <= 4'h0;
      tail_r          <= 2'h0;
      fifo_flush_r    <= 1'b1;
      o_cfg_ready_low <= 1'b0;
      o_load_complete <= 1'b0;
      o_init_done     <= 1'b0;
      o_init_done_oe  <= 1'b0;
      o_user_io_en    <= 1'b0;
      o_word_valid    <= 1'b0;
      o_word_data     <= {`PCL_DATA_W{1'b0}};
      o_error         <= 1'b0;
    end else if (i_ce) begin
      fifo_flush_r <= 1'b0;
      // Register stage keeps word outputs on flip-flops
      o_word_valid <= f_out_valid & i_word_ready;
      if (f_out_valid && i_word_ready)
        o_word_data <= f_out_data;
      // Restart from any state but ST_POR once the request pin goes low
      if (!req_s1_r && state_r != ST_POR) begin
        state_r         <= ST_POR;
        por_r           <= {`PCL_CNT_W{1'b0}};
        fifo_flush_r    <= 1'b1;
        o_cfg_ready_low <= 1'b0;
        o_load_complete <= 1'b0;
        o_init_done_oe  <= 1'b0;
        o_user_io_en    <= 1'b0;
        o_error         <= 1'b0;
      end else begin
        case (state_r)
          // Power-on delay, then wait for the request to be high
          ST_POR: begin
            o_load_complete <= 1'b0;
            if (por_r < `PCL_POR_CYC) begin
              por_r <= por_r + `PCL_ONE16;
            end else if (req_s1_r) begin
              o_cfg_ready_low <= 1'b1;
              words_r         <= {`PCL_CNT_W{1'b0}};
              edge_r          <= 4'h0;
              state_r         <= ST_LOAD;
            end
          end
          ST_LOAD: begin
            // Pauses with the clock low simply produce no edges
            // Edge group counter wraps at the selected ratio
            if (rise) begin
              edge_r <= (edge_r + `PCL_ONE4 >= ratio) ? 4'h0 : edge_r + `PCL_ONE4;
            end
            if (cap) begin
              // Overflow: status drops and the load is abandoned
              if (!f_in_ready) begin
                o_cfg_ready_low <= 1'b0;
                o_error         <= 1'b1;
                state_r         <= ST_ERR;
              end else begin
                words_r <= words_r + `PCL_ONE16;
                if (words_r == `PCL_OPT_WORD && dat_s1_r[`PCL_OPT_INIT_BIT]) begin
                  o_init_done    <= 1'b0;
                  o_init_done_oe <= 1'b1;
                end
              end
            end
            // Flag rises when the last word's clock group has ended
            if (fall && (edge_r == 4'h0) && (words_r == `PCL_IMG_WORDS)) begin
              o_load_complete <= 1'b1;
              tail_r          <= 2'h0;
              state_r         <= ST_TAIL;
            end
          end
          ST_TAIL: begin
            // Two falls after the flag start initialisation
            if (fall) begin
              tail_r <= tail_r + 2'h1;
              if (tail_r + 2'h1 == `PCL_TAIL_EDGES) begin
                state_r        <= ST_USER;
                o_user_io_en   <= 1'b1;
                o_init_done_oe <= 1'b0;
                o_init_done    <= 1'b1;
              end
            end
          end
          // Pins held high; clock edges are ignored here
          ST_USER: begin
            o_cfg_ready_low <= 1'b1;
            o_load_complete <= 1'b1;
          end
          ST_ERR: begin
            o_cfg_ready_low <= 1'b0;
          end
          default: begin
            state_r <= ST_POR;
          end
        endcase
      end
    end
  end
endmodule

/* File: test/pcl_loader_assertions.sv */
// Pin checks for the configuration loader
// Assumes binding to pcl_loader; sees its ports only
`timescale 1ns/1ps
module pcl_loader_assertions (
  input logic i_sys_clk,
  input logic i_rst,
  input logic i_reconfig_request_n,
  input logic o_cfg_ready_low,
  input logic o_load_complete,
  input logic o_init_done,
  input logic o_init_done_oe,
  input logic o_user_io_en,
  input logic o_word_valid,
  input logic o_error
);
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);
  por_status_a: assert property ($fell(i_rst) |-> !o_cfg_ready_low [*8]) else $error("status early");
  restart_clear_a: assert property ($fell(i_reconfig_request_n) |-> ##[0:4] !o_load_complete)
    else $error("restart kept flag");
  user_pins_a: assert property (o_user_io_en |-> o_cfg_ready_low && o_load_complete) else $error("user pins");
  init_release_a: assert property (o_user_io_en |-> o_init_done && !o_init_done_oe) else $error("init held");
  init_drive_a: assert property (o_init_done_oe |-> !o_init_done && !o_user_io_en) else $error("init drive");
  clock_ignored_a: assert property (o_user_io_en && i_reconfig_request_n && $past(i_reconfig_request_n, 4)
    |=> o_user_io_en && !o_word_valid) else $error("clock not ignored");
  tail_edges_a: assert property ($rose(o_load_complete) |=> !o_user_io_en [*6]) else $error("early user");
  error_block_a: assert property (o_error |-> !o_load_complete && !o_cfg_ready_low) else $error("error");
endmodule

/* File: test/pcl_host_model.sv */
// Host model: drives configuration clock and data bus
// Assumes the bench calls its tasks; timing is free of the system clock
`timescale 1ns/1ps
module pcl_host (
  output logic        o_cfg_clock,
  output logic [31:0] o_cfg_data
);
  initial begin
    o_cfg_clock = 1'b0;
    o_cfg_data  = 32'h0000_0000;
  end
  task automatic pulse;
    #100 o_cfg_clock = 1'b1;
    #100 o_cfg_clock = 1'b0;
  endtask
  task automatic send(input logic [31:0] w, input int r, input int gap);
    o_cfg_data = ~w;
    #(gap + 1);
    o_cfg_data = w;
    repeat (r) pulse();
  endtask
endmodule

/* File: test/pcl_loader_tb.sv */
// Self-checking bench for the configuration loader
// Assumes pcl_regs.vh on the include path and the host model
`timescale 1ns/1ps
`include "pcl_regs.vh"
module pcl_loader_tb;
  logic        clk = 1'b0, rst = 1'b1, req_n = 1'b1, dec = 1'b0, sec = 1'b0, rdy = 1'b1, stall = 1'b0;
  wire         cclk, rlow, done, idone, ioe, uio, wv, err;
  wire  [31:0] cdat, wdat;
  logic [31:0] img [$], got [$];
  int          miscompares = 0, comparisons = 0;
  always #12.5 clk = ~clk;
  always @(posedge clk) rdy <= #2 !stall && $urandom_range(1);
  always @(posedge clk) if (wv) got.push_back(wdat);
  pcl_host u_host (.o_cfg_clock(cclk), .o_cfg_data(cdat));
  pcl_loader u_pcl_loader (.i_sys_clk(clk), .i_rst(rst), .i_ce(1'b1), .i_reconfig_request_n(req_n),
    .i_cfg_clock(cclk), .i_cfg_data(cdat), .i_decompress_en(dec), .i_security_en(sec), .i_word_ready(rdy),
    .o_cfg_ready_low(rlow), .o_load_complete(done), .o_init_done(idone), .o_init_done_oe(ioe),
    .o_user_io_en(uio), .o_word_valid(wv), .o_word_data(wdat), .o_error(err));
  task automatic cycles(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  function automatic int ratio(input logic d, input logic s);
    return (d && s) ? 8 : (d || s) ? 4 : 1;
  endfunction
  task automatic load(input int n, input logic opt);
    logic [31:0] w;
    img = {};
    got = {};
    req_n = 1'b0;
    cycles(10);
    req_n = 1'b1;
    for (int i = 0; i < 300 && !rlow; i++) cycles(1);
    for (int i = 0; i < n; i++) begin
      w = $urandom;
      if (i == 0) w[0] = opt;
      img.push_back(w);
      u_host.send(w, ratio(dec, sec), $urandom_range(300));
      if (i == n - 2) check(done, 0);
    end
    cycles(20);
  endtask
  task automatic give_verdict;
    if (miscompares == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial begin
    void'($urandom(7530));
    cycles(10);
    rst = 1'b0;
    cycles(`PCL_POR_CYC + 4);
    check(rlow, 1);
    for (int m = 0; m < 4; m++) begin
      {sec, dec} = m[1:0];
      load(`PCL_IMG_WORDS, m[0]);
      check(done, 1);
      check(got.size(), `PCL_IMG_WORDS);
      foreach (got[i]) check(got[i], img[i]);
      check(ioe, m[0]);
      u_host.pulse();
      cycles(4);
      check(uio, 0);
      u_host.pulse();
      cycles(4);
      check({uio, idone, ioe}, 3'b110);
      repeat (3) u_host.pulse();
      cycles(8);
      check({got.size() == `PCL_IMG_WORDS, uio}, 2'b11);
    end
    stall = 1'b1;
    load(12, 1'b0);
    check({err, done}, 2'b10);
    give_verdict();
  end
  initial begin
    #2_000_000;
    miscompares++;
    give_verdict();
  end
endmodule
bind pcl_loader pcl_loader_assertions u_chk (.i_sys_clk, .i_rst, .i_reconfig_request_n, .o_cfg_ready_low,
  .o_load_complete, .o_init_done, .o_init_done_oe, .o_user_io_en, .o_word_valid, .o_error);
